// ==== interrupt_status_bank_tb.sv ====
// Self-checking testbench for the interrupt status bank
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_bank_tb;
  logic        CLOCK = 1'b0;
  logic        ARST_N = 1'b0;
  wire logic   CS_N, RD_N, WR_N, DATA_OE, MASTER_IRQ, HOLDOFF_IRQ, BYPASS_IRQ, WAKE;
  wire logic [7:0]  ADDR;
  wire logic [31:0] DATA_IN, DATA_OUT;
  logic [31:0] INT_ENABLE = '0, DROP_COUNT = 32'h7FFF_FFFF;
  logic [18:0] s = '0;  // One-bit sources, one per position
  wire logic [2:0]  GENERAL_PIN_EVENTS;
  wire logic   TX_FAULT, RX_FAULT, TX_RESULT_OVERFLOW, FRAME_DROPPED, POWER_EVENT;
  wire logic   TX_RESULT_FULL, RX_HALTED, RX_RESULT_FULL, STOP_TX_REQUEST, TX_HALTED;
  wire logic   TX_BUFFER_LOADED, COMPLETION_NOTIFY_MARKER, TX_PAYLOAD_WRITE, TX_PAYLOAD_FULL;
  wire logic   RX_PACKET_END, RX_WORD_READ;
  logic [7:0]  TX_FREE_BLOCKS = 8'h10, TX_SPACE_THRESHOLD = 8'h10;
  logic [7:0]  TX_RESULT_USED = 8'h05, TX_RESULT_THRESHOLD = 8'h05;
  logic [7:0]  RX_RESULT_USED = 8'h05, RX_RESULT_THRESHOLD = 8'h05;
  logic [15:0] RX_PACKET_LENGTH = 16'h0801, TIMER_COUNT = 16'h0000;
  logic [11:0] RECEIVE_WORD_COUNTDOWN = 12'h001;
  logic        LINE_INTERFACE_EVENT = 1'b0;
  int          n_errors = 0, checked = 0, cyc = 0, wakes = 0;
  logic [31:0] d;
  // Source pulses and the status word each should leave
  logic [18:0] tm [17] = '{19'h0_0001, 19'h0_0002, 19'h0_0004, 19'h0_0008, 19'h0_0010,
    19'h0_0020, 19'h0_0040, 19'h0_0080, 19'h0_0300, 19'h0_0C00, 19'h0_3000, 19'h0_4000,
    19'h0_8000, 19'h0_0100, 19'h0_0400, 19'h0_1000, 19'h7_0000};
  logic [31:0] te [17] = '{32'h0000_2000, 32'h0000_4000, 32'h0001_0000, 32'h0000_0040,
    32'h0002_0000, 32'h0000_0100, 32'h0100_0000, 32'h0000_0010, 32'h0200_0000,
    32'h0020_0000, 32'h0000_0400, 32'h0000_8000, 32'h0010_0000, 32'h0, 32'h0, 32'h0,
    32'h0000_0007};

  assign {GENERAL_PIN_EVENTS, RX_WORD_READ, RX_PACKET_END, TX_PAYLOAD_FULL, TX_PAYLOAD_WRITE,
    COMPLETION_NOTIFY_MARKER, TX_BUFFER_LOADED, TX_HALTED, STOP_TX_REQUEST, RX_RESULT_FULL,
    RX_HALTED, TX_RESULT_FULL, POWER_EVENT, FRAME_DROPPED, TX_RESULT_OVERFLOW, RX_FAULT,
    TX_FAULT} = s;

  isb_status_bank u_isb_status_bank (.*);
  isb_host_model  u_isb_host_model (.*);

  // 125 MHz clock
  always #4 CLOCK = ~CLOCK;

  // Wake pulse count and run ceiling
  always @(posedge CLOCK) begin
    cyc++;
    if (WAKE === 1'b1) wakes++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Pulse sources one cycle, check outputs and word, clear all and recheck
  task automatic ev(input logic [18:0] m, input logic [31:0] e);
    @(negedge CLOCK) s = m;
    @(negedge CLOCK) s = '0;
    chk(MASTER_IRQ, |(e & INT_ENABLE));
    chk(HOLDOFF_IRQ, |(e & INT_ENABLE & 32'hFFFD_FFFF));
    chk(BYPASS_IRQ, e[17] & INT_ENABLE[17]);
    u_isb_host_model.rd(8'h58, d);
    chk(d, e);
    u_isb_host_model.wr(8'h58, 32'hFFFF_FFFF);
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h0);
  endtask : ev

  // Main sequence
  initial begin
    repeat (10) @(negedge CLOCK);
    ARST_N = 1'b1;
    fork
      u_isb_host_model.rd(8'h58, d);
      // Data pins driven while the read is held
      begin
        repeat (2) @(negedge CLOCK);
        chk(DATA_OE, 32'h1);
      end
    join
    chk(d, 32'h0);
    for (int e = 0; e < 2; e++) begin
      INT_ENABLE = e ? 32'h7FFF_FFFF : 32'h0;
      for (int i = 0; i < 17; i++) ev(tm[i], te[i]);
    end
    INT_ENABLE = '0;
    @(negedge CLOCK) TIMER_COUNT = 16'hFFFF;
    ev(19'h0, 32'h0008_0000);
    @(negedge CLOCK) DROP_COUNT = 32'h8000_0000;
    ev(19'h0, 32'h0080_0000);
    @(negedge CLOCK) TX_FREE_BLOCKS = 8'h11;
    ev(19'h0, 32'h0000_0200);
    @(negedge CLOCK) TX_RESULT_USED = 8'h06;
    ev(19'h0, 32'h0000_0080);
    @(negedge CLOCK) RX_RESULT_USED = 8'h06;
    ev(19'h0, 32'h0000_0008);
    RX_PACKET_LENGTH = 16'h0800;
    ev(19'h0_4000, 32'h0);
    RECEIVE_WORD_COUNTDOWN = 12'h002;
    ev(19'h0_8000, 32'h0);
    INT_ENABLE = 32'h0002_0000;
    ev(19'h0_0011, 32'h0002_2000);
    INT_ENABLE = 32'h8000_0000;
    @(negedge CLOCK);
    chk(MASTER_IRQ, 1'b1);
    u_isb_host_model.wr(8'h58, 32'hFFFF_FFFF);
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h8000_0000);
    INT_ENABLE = '0;
    u_isb_host_model.wr(8'h58, 32'hFFFF_FFFF);
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h0);
    INT_ENABLE = 32'h0004_0000;
    LINE_INTERFACE_EVENT = 1'b1;
    u_isb_host_model.wr(8'h58, 32'hFFFF_FFFF);
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h0004_0000);
    u_isb_host_model.rd(8'h5C, d);
    chk(d, 32'h0);
    LINE_INTERFACE_EVENT = 1'b0;
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h0);
    INT_ENABLE = '0;
    // Receiver fault stays while a transmit fault races its own clear
    @(negedge CLOCK) s = 19'h0_0002;
    @(negedge CLOCK) s = '0;
    fork
      u_isb_host_model.wr(8'h58, 32'h0000_2000);
      begin
        @(negedge CLOCK) s = 19'h0_0001;
        @(negedge CLOCK) s = '0;
      end
    join
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h0000_6000);
    u_isb_host_model.wr(8'h58, 32'h0000_6000);
    u_isb_host_model.rd(8'h58, d);
    chk(d, 32'h0);
    chk(wakes, 0);
    u_isb_host_model.wr(8'h64, 32'h0000_0000);
    @(negedge CLOCK);
    chk(wakes, 1);
    tally_and_finish();
  end
endmodule : interrupt_status_bank_tb
`default_nettype wire

// ==== isb_consts.svh ====
// Constants for the interrupt status bank: offsets, field positions, limits
`ifndef ISB_CONSTS_SVH
`define ISB_CONSTS_SVH

// Register byte offsets on the host bus
`define ISB_STATUS_OFFSET    8'h58
`define ISB_BYTE_TEST_OFFSET 8'h64

// Flag positions within the status word
`define ISB_BIT_SOFTWARE     31
`define ISB_BIT_TX_HALTED    25
`define ISB_BIT_RX_HALTED    24
`define ISB_BIT_DROP_MID     23
`define ISB_BIT_TX_DONE      21
`define ISB_BIT_RX_COUNT     20
`define ISB_BIT_TIMER        19
`define ISB_BIT_LINE_EVENT   18
`define ISB_BIT_POWER        17
`define ISB_BIT_TX_RES_OVF   16
`define ISB_BIT_OVERSIZE     15
`define ISB_BIT_RX_FAULT     14
`define ISB_BIT_TX_FAULT     13
`define ISB_BIT_TX_OVERRUN   10
`define ISB_BIT_TX_SPACE     9
`define ISB_BIT_TX_RES_FULL  8
`define ISB_BIT_TX_RES_LEVEL 7
`define ISB_BIT_FRAME_DROP   6
`define ISB_BIT_RX_RES_FULL  4
`define ISB_BIT_RX_RES_LEVEL 3
`define ISB_BIT_PINS_HI      2
`define ISB_BIT_PINS_LO      0

// Reserved positions, the mirrored position and the status reset value
`define ISB_RESERVED_MASK    32'h7C40_1820
`define ISB_MIRROR_MASK      32'h0004_0000
`define ISB_POWER_MASK       32'h0002_0000
`define ISB_STATUS_RESET     32'h0000_0000
`define ISB_WORD_ZERO        32'h0000_0000

// Event limits
`define ISB_OVERSIZE_LIMIT   16'h0800
`define ISB_TIMER_WRAP       16'hFFFF
`define ISB_TIMER_ZERO       16'h0000
`define ISB_DROP_MSB         31

`endif

// ==== isb_flag_cell.sv ====
// Sticky flag storage: set wins over clear, reserved bits zero, mirror bits follow
`timescale 1ns/1ps
`default_nettype none
`include "isb_consts.svh"
module isb_flag_cell #(
  parameter logic [31:0] RESERVED = `ISB_RESERVED_MASK,
  parameter logic [31:0] MIRROR   = `ISB_MIRROR_MASK
) (
  input wire logic clock,
  input wire logic arst_n,
  isb_flag_if.bank fl
);

  // Registered state and its next value
  isb_pkg::isb_cell_t state;
  isb_pkg::isb_cell_t next_state;
  // Per-bit next flag
  logic [31:0]        next_flag;

  // Per-bit update rule
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (RESERVED[i]) begin : g_res
        assign next_flag[i] = 1'b0;
      end else if (MIRROR[i]) begin : g_mir
        assign next_flag[i] = fl.set[i];
      end else begin : g_sticky
        assign next_flag[i] = fl.set[i] | (state.flag[i] & ~fl.clear[i]);
      end
    end
  endgenerate

  // Next state
  always_comb begin
    next_state      = state;
    next_state.flag = next_flag;
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state.flag <= `ISB_STATUS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Stored flags out
  assign fl.flag = state.flag;

endmodule : isb_flag_cell
`default_nettype wire

// ==== isb_flag_if.sv ====
// Set, clear and flag vectors between the bank control and its flag storage
`timescale 1ns/1ps
`default_nettype none
interface isb_flag_if;
  // Hardware set requests, one per bit
  logic [31:0] set;
  // Host write-one clear requests, one per bit
  logic [31:0] clear;
  // Stored flags
  logic [31:0] flag;
  // Storage side
  modport bank (input set, input clear, output flag);
  // Control side
  modport ctrl (output set, output clear, input flag);
endinterface : isb_flag_if
`default_nettype wire

// ==== isb_host_model.sv ====
// Host processor model driving the SRAM-like register bus
`timescale 1ns/1ps
`default_nettype none
module isb_host_model (
  input  wire logic        CLOCK,
  output var  logic        CS_N,
  output var  logic        RD_N,
  output var  logic        WR_N,
  output var  logic [7:0]  ADDR,
  output var  logic [31:0] DATA_IN,
  input  wire logic [31:0] DATA_OUT
);
  // Idle bus from time zero
  initial begin
    {CS_N, RD_N, WR_N, ADDR, DATA_IN} = {3'b111, 40'h00_0000_0000};
  end

  // One write cycle, then strobe high a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge CLOCK);
    {CS_N, WR_N, ADDR, DATA_IN} = {2'b00, a, d};
    @(negedge CLOCK);
    // Released lines show the inverse of the last value
    {CS_N, WR_N, ADDR, DATA_IN} = {2'b11, ~a, ~d};
    @(negedge CLOCK);
  endtask : wr

  // Read held until the answer has stood one cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge CLOCK);
    {CS_N, RD_N, ADDR} = {2'b00, a};
    repeat (2) @(negedge CLOCK);
    d = DATA_OUT;
    {CS_N, RD_N, ADDR} = {2'b11, ~a};
  endtask : rd
endmodule : isb_host_model
`default_nettype wire

// ==== isb_pkg.sv ====
// Types shared by the interrupt status bank modules
`default_nettype none
package isb_pkg;

  // One status word
  typedef logic [31:0] isb_word_t;

  // State of the flag storage cell
  typedef struct packed {
    isb_word_t flag;
  } isb_cell_t;

  // State of the bank's control logic
  typedef struct packed {
    logic      prev_write;
    logic      prev_tx_halt;
    logic      prev_rx_halt;
    logic      prev_drop_msb;
    logic      prev_timer_zero;
    logic      prev_tx_space;
    logic      prev_tx_full;
    logic      prev_rx_full;
    logic      prev_tx_level;
    logic      prev_rx_level;
    logic      wake;
    logic      read_active;
    isb_word_t read_data;
  } isb_ctl_t;

endpackage : isb_pkg
`default_nettype wire

// ==== isb_status_bank.sv ====
// Interrupt status bank: event capture, host read and write-one clear
`timescale 1ns/1ps
`default_nettype none
`include "isb_consts.svh"

// Behaviour
// - Host writing one clears flag
// - Software flag set while its enable high
// - Transmit halted flag on stop and halt
// - Receive halted flag when receiver halts
// - Drop counter midpoint crossing sets flag
// - Marked buffer loaded sets completion flag
// - Receive word countdown reaching end sets flag
// - Timer wrap zero to FFFF sets flag
// - Line event bit mirrors, ignores writes
// - Power event flag independent of pin
// - Only byte test write wakes device
// - Result FIFO overflow sets flag
// - Packet over 2048 bytes sets flag
// - Receiver fault sets flag
// - Transmitter fault sets flag
// - Write into full payload FIFO flags
// - Free space above threshold sets flag
// - Result FIFO full sets flags
// - Result FIFO level above threshold sets flags
// - Every dropped frame sets flag
// - Three pin events latched, reset zero
// - Power event skips holdoff interval
// - Flags record events regardless of enable
// - Master interrupt on any enabled flag
module isb_status_bank #(
  parameter int ADDR_W  = 8,   // Host address width, byte address
  parameter int LEN_W   = 16,  // Received packet length width
  parameter int COUNT_W = 12,  // Receive word countdown width
  parameter int LEVEL_W = 8    // FIFO level and threshold width
) (
  input  wire logic               CLOCK,
  input  wire logic               ARST_N,
  // Host bus
  // Active-low level strobes, write taken once
  input  wire logic               CS_N,
  input  wire logic               RD_N,
  input  wire logic               WR_N,
  input  wire logic [ADDR_W-1:0]  ADDR,
  input  wire logic [31:0]        DATA_IN,
  output logic      [31:0]        DATA_OUT,
  output logic                    DATA_OE,
  // Enable mask from the enable register
  // Gates interrupt lines; bit 31 also sets the software flag
  input  wire logic [31:0]        INT_ENABLE,
  // Transmit path
  // Pulses one cycle wide, levels may stay high
  input  wire logic               STOP_TX_REQUEST,
  input  wire logic               TX_HALTED,
  input  wire logic               TX_BUFFER_LOADED,
  input  wire logic               COMPLETION_NOTIFY_MARKER,
  input  wire logic               TX_FAULT,
  input  wire logic               TX_PAYLOAD_WRITE,
  input  wire logic               TX_PAYLOAD_FULL,
  input  wire logic [LEVEL_W-1:0] TX_FREE_BLOCKS,
  input  wire logic [LEVEL_W-1:0] TX_SPACE_THRESHOLD,
  input  wire logic               TX_RESULT_OVERFLOW,
  input  wire logic               TX_RESULT_FULL,
  input  wire logic [LEVEL_W-1:0] TX_RESULT_USED,
  input  wire logic [LEVEL_W-1:0] TX_RESULT_THRESHOLD,
  // Receive path
  // Length and countdown qualify their pulses
  input  wire logic               RX_HALTED,
  input  wire logic [31:0]        DROP_COUNT,
  input  wire logic               FRAME_DROPPED,
  input  wire logic               RX_FAULT,
  input  wire logic               RX_PACKET_END,
  input  wire logic [LEN_W-1:0]   RX_PACKET_LENGTH,
  input  wire logic               RX_WORD_READ,
  input  wire logic [COUNT_W-1:0] RECEIVE_WORD_COUNTDOWN,
  input  wire logic               RX_RESULT_FULL,
  input  wire logic [LEVEL_W-1:0] RX_RESULT_USED,
  input  wire logic [LEVEL_W-1:0] RX_RESULT_THRESHOLD,
  // Other sources
  // Line event is a level, mirrored
  input  wire logic [15:0]        TIMER_COUNT,
  input  wire logic               LINE_INTERFACE_EVENT,
  input  wire logic               POWER_EVENT,
  input  wire logic [2:0]         GENERAL_PIN_EVENTS,
  // Interrupt and wake outputs
  // Holdoff timer and wake logic sit outside
  output logic                    MASTER_IRQ,
  output logic                    HOLDOFF_IRQ,
  output logic                    BYPASS_IRQ,
  output logic                    WAKE
);

  // Elaboration checks
  // Decode compares eight address bits
  // Length must exceed the oversize limit
  // Levels are plain unsigned compares
  // Wider than sixteen bits buys nothing
  generate
    if (ADDR_W < 8) begin : g_chk_addr
      $error("ADDR_W must reach the status offset");
    end
    if (LEN_W < 13) begin : g_chk_len
      $error("LEN_W must hold lengths above the oversize limit");
    end
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_chk_count
      $error("COUNT_W must be 1 to 16");
    end
    if (LEVEL_W < 1 || LEVEL_W > 16) begin : g_chk_level
      $error("LEVEL_W must be 1 to 16");
    end
  endgenerate

  // Widened comparison constants
  // Sized to the ports they meet
  localparam logic [LEN_W-1:0]   OVERSIZE = LEN_W'(`ISB_OVERSIZE_LIMIT);
  localparam logic [COUNT_W-1:0] LAST_ONE = COUNT_W'(1);

  // Control state and its next value
  // Edge history lives here
  // History resets to each source's idle level
  // So no false edge follows reset
  // Read data and wake are registered too
  isb_pkg::isb_ctl_t state;
  isb_pkg::isb_ctl_t next_state;

  // Link to flag storage
  // Storage keeps the sticky bits
  isb_flag_if fl ();

  // Decoded host cycle
  // Combinational from the live bus pins
  logic write_active;          // Host write strobe held
  logic write_take;            // First cycle of a write
  logic read_active;           // Host read strobe held
  logic hit_status;            // Address selects the status word
  logic hit_byte_test;         // Address selects the byte test word

  // Source conditions, one per flag
  // Named to keep the set vector readable
  logic tx_halt_now;           // Stop requested and halted
  logic timer_zero_now;        // Timer sits at zero
  logic tx_space_now;          // Free space above threshold
  logic tx_level_now;          // Transmit results above level
  logic rx_level_now;          // Receive results above level
  logic [31:0] set_vec;        // Set requests to storage
  logic [31:0] clear_vec;      // Clear requests to storage
  logic [31:0] active;         // Flags gated by enable

  // Host strobe decode
  // Held write strobe clears only once
  // Take qualifies on the first strobe cycle
  // Host raises the strobe between writes
  // Reads taken on every strobed edge
  always_comb begin
    write_active  = !CS_N && !WR_N;
    read_active   = !CS_N && !RD_N;
    write_take    = write_active && !state.prev_write;
    hit_status    = (ADDR[7:0] == `ISB_STATUS_OFFSET);
    hit_byte_test = (ADDR[7:0] == `ISB_BYTE_TEST_OFFSET);
  end

  // Level and threshold conditions
  // Strictly greater than the threshold
  // Equal level does not count
  // Levels here, rising edges below
  // So a host clear sticks while true
  always_comb begin
    tx_halt_now    = STOP_TX_REQUEST && TX_HALTED;
    timer_zero_now = (TIMER_COUNT == `ISB_TIMER_ZERO);
    tx_space_now   = (TX_FREE_BLOCKS > TX_SPACE_THRESHOLD);
    tx_level_now   = (TX_RESULT_USED > TX_RESULT_THRESHOLD);
    rx_level_now   = (RX_RESULT_USED > RX_RESULT_THRESHOLD);
  end

  // Set requests; flags record events whatever the enables say
  // Pulse sources set on every high cycle
  // Level sources set when they become true
  // Software flag set while enabled
  // So its clear does not stick then
  // Fields qualify oversize and countdown
  always_comb begin
    set_vec = `ISB_WORD_ZERO;
    set_vec[`ISB_BIT_SOFTWARE] = INT_ENABLE[`ISB_BIT_SOFTWARE];
    set_vec[`ISB_BIT_TX_HALTED] = tx_halt_now && !state.prev_tx_halt;
    set_vec[`ISB_BIT_RX_HALTED] = RX_HALTED && !state.prev_rx_halt;
    set_vec[`ISB_BIT_DROP_MID] = DROP_COUNT[`ISB_DROP_MSB]
                                 && !state.prev_drop_msb;
    set_vec[`ISB_BIT_TX_DONE] = TX_BUFFER_LOADED && COMPLETION_NOTIFY_MARKER;
    set_vec[`ISB_BIT_RX_COUNT] = RX_WORD_READ
                                 && (RECEIVE_WORD_COUNTDOWN == LAST_ONE);
    set_vec[`ISB_BIT_TIMER] = state.prev_timer_zero
                              && (TIMER_COUNT == `ISB_TIMER_WRAP);
    set_vec[`ISB_BIT_LINE_EVENT] = LINE_INTERFACE_EVENT;
    set_vec[`ISB_BIT_POWER] = POWER_EVENT;
    set_vec[`ISB_BIT_TX_RES_OVF] = TX_RESULT_OVERFLOW;
    set_vec[`ISB_BIT_OVERSIZE] = RX_PACKET_END
                                 && (RX_PACKET_LENGTH > OVERSIZE);
    set_vec[`ISB_BIT_RX_FAULT] = RX_FAULT;
    set_vec[`ISB_BIT_TX_FAULT] = TX_FAULT;
    set_vec[`ISB_BIT_TX_OVERRUN] = TX_PAYLOAD_WRITE && TX_PAYLOAD_FULL;
    set_vec[`ISB_BIT_TX_SPACE] = tx_space_now && !state.prev_tx_space;
    set_vec[`ISB_BIT_TX_RES_FULL] = TX_RESULT_FULL && !state.prev_tx_full;
    set_vec[`ISB_BIT_RX_RES_FULL] = RX_RESULT_FULL && !state.prev_rx_full;
    set_vec[`ISB_BIT_TX_RES_LEVEL] = tx_level_now && !state.prev_tx_level;
    set_vec[`ISB_BIT_RX_RES_LEVEL] = rx_level_now && !state.prev_rx_level;
    set_vec[`ISB_BIT_FRAME_DROP] = FRAME_DROPPED;
    set_vec[`ISB_BIT_PINS_HI:`ISB_BIT_PINS_LO] = GENERAL_PIN_EVENTS;
  end

  // Host write-one clears on the status word
  // Only the take cycle clears
  // Other offsets never reach storage
  // A same-cycle set still wins
  always_comb begin
    if (write_take && hit_status) begin
      clear_vec = DATA_IN;
    end else begin
      clear_vec = `ISB_WORD_ZERO;
    end
  end

  // Drive the storage link
  // Set and clear meet in storage
  assign fl.set   = set_vec;
  assign fl.clear = clear_vec;

  // Sticky flag storage
  // Reserved and mirror maps fixed at build
  // Storage needs no register map
  isb_flag_cell #(
    .RESERVED (`ISB_RESERVED_MASK),
    .MIRROR   (`ISB_MIRROR_MASK)
  ) u_cell (
    .clock  (CLOCK),
    .arst_n (ARST_N),
    .fl     (fl.bank)
  );

  // Next control state
  // Wake pulse lasts one cycle
  // Raised only by a byte test write take
  // Read data captured on each read cycle
  // Held until the next read
  // Other offsets read back as zero
  always_comb begin
    next_state                 = state;
    // Edge detector history
    next_state.prev_write      = write_active;
    next_state.prev_tx_halt    = tx_halt_now;
    next_state.prev_rx_halt    = RX_HALTED;
    next_state.prev_drop_msb   = DROP_COUNT[`ISB_DROP_MSB];
    next_state.prev_timer_zero = timer_zero_now;
    next_state.prev_tx_space   = tx_space_now;
    next_state.prev_tx_full    = TX_RESULT_FULL;
    next_state.prev_rx_full    = RX_RESULT_FULL;
    next_state.prev_tx_level   = tx_level_now;
    next_state.prev_rx_level   = rx_level_now;
    next_state.wake            = write_take && hit_byte_test;
    next_state.read_active     = read_active;
    // Read data register
    if (read_active && hit_status) begin
      next_state.read_data = fl.flag & ~`ISB_RESERVED_MASK;
    end else if (read_active) begin
      // Other offsets are not served here
      next_state.read_data = `ISB_WORD_ZERO;
    end else begin
      // Hold the last word between reads
      next_state.read_data = state.read_data;
    end
  end

  // Control state register
  // Reset values are constants only
  // History clears to source idle level
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state.prev_write      <= 1'b0;
      state.prev_tx_halt    <= 1'b0;
      state.prev_rx_halt    <= 1'b0;
      state.prev_drop_msb   <= 1'b0;
      state.prev_timer_zero <= 1'b0;
      state.prev_tx_space   <= 1'b0;
      state.prev_tx_full    <= 1'b0;
      state.prev_rx_full    <= 1'b0;
      state.prev_tx_level   <= 1'b0;
      state.prev_rx_level   <= 1'b0;
      state.wake            <= 1'b0;
      state.read_active     <= 1'b0;
      state.read_data       <= `ISB_WORD_ZERO;
    end else begin
      state <= next_state;
    end
  end

  // Interrupt outputs
  // Combinational from flags and enables
  // Follows a clear on its taking edge
  // Power flag on its own line
  // Holdoff timer must not delay it
  // Other enabled flags go through holdoff
  always_comb begin
    active      = fl.flag & INT_ENABLE;
    MASTER_IRQ  = |active;
    BYPASS_IRQ  = |(active & `ISB_POWER_MASK);
    HOLDOFF_IRQ = |(active & ~`ISB_POWER_MASK);
  end

  // Host data pins and wake pulse
  // Enable needs registered and live strobe
  // Pins released when the host lets go
  // Wake from a flop, free of glitches
  assign DATA_OUT = state.read_data;
  assign DATA_OE  = state.read_active && read_active;
  assign WAKE     = state.wake;

endmodule : isb_status_bank
`default_nettype wire

// ==== isb_status_bank_assertions.sv ====
// Checker for the interrupt status bank: wake, interrupt outputs and read data
`timescale 1ns/1ps
`default_nettype none
`include "isb_consts.svh"
module isb_status_bank_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              CLOCK,
  input wire logic              ARST_N,
  input wire logic              CS_N,
  input wire logic              RD_N,
  input wire logic              WR_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0]       DATA_OUT,
  input wire logic [31:0]       INT_ENABLE,
  input wire logic              TX_FAULT,
  input wire logic              POWER_EVENT,
  input wire logic              LINE_INTERFACE_EVENT,
  input wire logic              MASTER_IRQ,
  input wire logic              HOLDOFF_IRQ,
  input wire logic              BYPASS_IRQ,
  input wire logic              WAKE
);
  logic      prev_wr;  // Write strobe seen on the last edge
  wire logic wr_on   = !CS_N && !WR_N;
  // First edge of a write to the byte test word
  wire logic wt      = wr_on && !prev_wr && ADDR == ADDR_W'(`ISB_BYTE_TEST_OFFSET);

  // Tracks the strobe so a held write counts once
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_wr <= 1'b0;
    end else begin
      prev_wr <= wr_on;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  wake_on_write_a: assert property (wt |=> WAKE)
    else $error("no wake after byte test write");
  power_no_wake_a: assert property (POWER_EVENT && !wt |=> !WAKE)
    else $error("wake without byte test write");
  irq_split_a: assert property (MASTER_IRQ == (HOLDOFF_IRQ || BYPASS_IRQ))
    else $error("master differs from its two parts");
  bypass_power_a: assert property (POWER_EVENT && INT_ENABLE[17] ##1 INT_ENABLE[17]
    |-> BYPASS_IRQ)
    else $error("power event missing on bypass line");
  holdoff_excl_a: assert property (INT_ENABLE == 32'h0002_0000 |-> !HOLDOFF_IRQ)
    else $error("power event reached holdoff line");
  mask_gate_a: assert property (INT_ENABLE == 32'h0000_0000 |-> !MASTER_IRQ)
    else $error("interrupt with every enable clear");
  fault_irq_a: assert property (TX_FAULT && INT_ENABLE[13] ##1 INT_ENABLE[13]
    |-> MASTER_IRQ)
    else $error("transmit fault not flagged");
  line_on_a: assert property (LINE_INTERFACE_EVENT && INT_ENABLE[18] [*2] |-> MASTER_IRQ)
    else $error("line event not mirrored");
  line_off_a: assert property (!LINE_INTERFACE_EVENT ##1 (!LINE_INTERFACE_EVENT
    && INT_ENABLE == 32'h0004_0000) |-> !MASTER_IRQ)
    else $error("line mirror stuck high");
  reserved_zero_a: assert property (!CS_N && !RD_N |=>
    (DATA_OUT & `ISB_RESERVED_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  wake_c: cover property (wt ##1 WAKE);
  bypass_c: cover property (BYPASS_IRQ && !HOLDOFF_IRQ);
  read_c: cover property (!CS_N && !RD_N [*2]);
endmodule : isb_status_bank_sva
bind isb_status_bank isb_status_bank_sva #(.ADDR_W(ADDR_W)) u_isb_status_bank_sva (.*);
`default_nettype wire
